// ===== design/xfer_pkg.sv
package xfer_pkg;

    // ------------------------------------------------------------------
    // Opcodes and prefix
    // ------------------------------------------------------------------
    localparam logic [7:0] ESC_PREFIX = 8'ha5;
    localparam logic [7:0] OP_GT      = 8'h38;
    localparam logic [7:0] OP_LE      = 8'h28;
    localparam logic [7:0] OP_IND     = 8'h73;
    localparam logic [7:0] OP_BCLR    = 8'h30;

    // ------------------------------------------------------------------
    // Instruction lengths in bytes
    // ------------------------------------------------------------------
    localparam logic [2:0] LEN_COND_BIN = 3'h3;
    localparam logic [2:0] LEN_COND_SRC = 3'h2;
    localparam logic [2:0] LEN_IND      = 3'h1;
    localparam logic [2:0] LEN_BCLR     = 3'h3;

    // ------------------------------------------------------------------
    // Execution time in states (one state is one pclk cycle)
    // ------------------------------------------------------------------
    localparam logic [2:0] ST_COND_BIN_NT = 3'h2;
    localparam logic [2:0] ST_COND_BIN_T  = 3'h5;
    localparam logic [2:0] ST_COND_SRC_NT = 3'h1;
    localparam logic [2:0] ST_COND_SRC_T  = 3'h4;
    localparam logic [2:0] ST_IND         = 3'h5;
    localparam logic [2:0] ST_BCLR_NT     = 3'h2;
    localparam logic [2:0] ST_BCLR_T      = 3'h5;
    localparam logic [2:0] ST_NONE        = 3'h1;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_NEXT_PC = 8'h08;
    localparam logic [7:0]  REG_COUNT   = 8'h0c;
    localparam int          CTRL_EN_BIT = 0;
    localparam logic        CTRL_EN_RST = 1'b1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        K_NONE, K_GT, K_LE, K_IND, K_BCLR
    } kind_t;

    typedef struct packed {
        logic [7:0] b3;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] b0;
    } instr_t;

    typedef struct packed {
        logic        zero_flag;
        logic        carry_flag;
        logic [7:0]  acc;
        logic [15:0] data_pointer;
    } core_state_t;

    typedef struct packed {
        logic [25:0] rsvd;
        kind_t       kind;
        logic        taken;
        logic        busy;
        logic        src_mode;
    } status_t;

endpackage : xfer_pkg

// ===== design/xfer_decode.sv
`timescale 1ns/1ps
module xfer_decode (
    input  xfer_pkg::instr_t instr,    // fetched bytes, b0 first
    input  wire logic        src_mode, // 1 source mode, 0 binary
    output xfer_pkg::kind_t  kind,     // decoded transfer kind
    output logic [2:0]       len,      // bytes consumed
    output logic [7:0]       rel,      // signed displacement
    output logic [7:0]       bit_addr  // tested bit address
);

    always_comb begin
        kind     = xfer_pkg::K_NONE;
        len      = 3'h1;
        rel      = 8'h00;
        bit_addr = instr.b1;
        if (!src_mode && instr.b0 == xfer_pkg::ESC_PREFIX) begin
            len = xfer_pkg::LEN_COND_BIN;
            rel = instr.b2;
            if (instr.b1 == xfer_pkg::OP_GT) begin
                kind = xfer_pkg::K_GT;
            end else if (instr.b1 == xfer_pkg::OP_LE) begin
                kind = xfer_pkg::K_LE;
            end
        end else if (src_mode && instr.b0 == xfer_pkg::OP_GT) begin
            kind = xfer_pkg::K_GT;
            len  = xfer_pkg::LEN_COND_SRC;
            rel  = instr.b1;
        end else if (src_mode && instr.b0 == xfer_pkg::OP_LE) begin
            kind = xfer_pkg::K_LE;
            len  = xfer_pkg::LEN_COND_SRC;
            rel  = instr.b1;
        end else if (instr.b0 == xfer_pkg::OP_IND) begin
            kind = xfer_pkg::K_IND;
            len  = xfer_pkg::LEN_IND;
        end else if (instr.b0 == xfer_pkg::OP_BCLR) begin
            kind = xfer_pkg::K_BCLR;
            len  = xfer_pkg::LEN_BCLR;
            rel  = instr.b2;
        end
    end

endmodule : xfer_decode

// ===== design/branch_jump_execute.sv
// Operation
// - Jump-if-greater advances the program counter past itself and adds the displacement only when zero and carry are both clear.
// - The indirect jump loads the data pointer plus the unsigned accumulator into the low sixteen program counter bits.
// - The indirect jump leaves the accumulator and the data pointer unchanged.
// - Fetching resumes from the computed address, and the one-byte indirect jump takes five states in both modes.
// - Jump-if-bit-clear advances to the next instruction and adds the third-byte displacement if the bit is zero.
// - Jump-if-bit-clear only reads the tested bit and never writes it.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module branch_jump_execute #(
    parameter int PC_W = 24
) (
    input  wire logic              pclk,        // core clock
    input  wire logic              presetn,     // async reset, low
    input  wire logic [7:0]        paddr,       // APB address
    input  wire logic              psel,        // APB select
    input  wire logic              penable,     // APB enable
    input  wire logic              pwrite,      // APB direction
    input  wire logic [31:0]       pwdata,      // APB write data
    output logic [31:0]            prdata,      // APB read data
    output logic                   pready,      // APB ready
    output logic                   pslverr,     // APB error
    input  wire logic              src_mode,    // mode strap
    input  wire logic              req_valid,   // instruction offered
    output logic                   req_ready,   // instruction taken
    input  wire logic [PC_W-1:0]   req_pc,      // address of byte 0
    input  xfer_pkg::instr_t       req_instr,   // fetched bytes
    input  xfer_pkg::core_state_t  core,        // flags and operands
    output logic                   bit_rd,      // bit read strobe
    output logic [7:0]             bit_addr,    // bit address
    input  wire logic              bit_value,   // bit read data
    output logic                   done,        // result pulse
    output logic                   done_hit,    // opcode recognised
    output logic                   done_taken,  // branch taken
    output logic [PC_W-1:0]        next_pc      // fetch address
);

    typedef enum logic [1:0] {S_IDLE, S_BIT, S_WAIT} state_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [PC_W-1:0] rel_add(
        input logic [PC_W-1:0] b,
        input logic [7:0]      r
    );
        return b + {{(PC_W-8){r[7]}}, r};
    endfunction : rel_add

    function automatic logic [2:0] st_count(
        input xfer_pkg::kind_t k,
        input logic            src,
        input logic            t
    );
        logic [2:0] n;
        unique case (k)
            xfer_pkg::K_GT, xfer_pkg::K_LE: begin
                if (src) begin
                    n = t ? xfer_pkg::ST_COND_SRC_T : xfer_pkg::ST_COND_SRC_NT;
                end else begin
                    n = t ? xfer_pkg::ST_COND_BIN_T : xfer_pkg::ST_COND_BIN_NT;
                end
            end
            xfer_pkg::K_IND:  n = xfer_pkg::ST_IND;
            xfer_pkg::K_BCLR:
                n = t ? xfer_pkg::ST_BCLR_T : xfer_pkg::ST_BCLR_NT;
            default:          n = xfer_pkg::ST_NONE;
        endcase
        return n;
    endfunction : st_count

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_t             state_q;
    xfer_pkg::kind_t    kind_q;
    logic [PC_W-1:0]    base_q;
    logic [7:0]         rel_q;
    logic               zf_q;
    logic               cf_q;
    logic [7:0]         acc_q;
    logic [15:0]        dp_q;
    logic               bitv_q;
    logic [2:0]         cnt_q;
    logic               src_mode_q;
    logic               mode_cap_q;
    logic               en_q;
    logic [15:0]        count_q;
    logic               req_ready_q;
    logic               bit_rd_q;
    logic [7:0]         bit_addr_q;
    logic               done_q;
    logic               done_hit_q;
    logic               taken_q;
    logic [PC_W-1:0]    next_pc_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    xfer_pkg::kind_t    dec_kind;
    logic [2:0]         dec_len;
    logic [7:0]         dec_rel;
    logic [7:0]         dec_bit;
    logic               take;
    logic [PC_W-1:0]    base;
    logic               gt_cond;
    logic               le_cond;
    logic               jcond;
    logic [15:0]        ind_sum;

    xfer_decode u_dec (
        .instr    (req_instr),
        .src_mode (src_mode_q),
        .kind     (dec_kind),
        .len      (dec_len),
        .rel      (dec_rel),
        .bit_addr (dec_bit)
    );
    assign take    = req_valid && req_ready_q;
    assign base    = req_pc + PC_W'(dec_len);
    assign gt_cond = !core.zero_flag && !core.carry_flag;
    assign le_cond = core.zero_flag || core.carry_flag;
    assign jcond   = (dec_kind == xfer_pkg::K_GT) ? gt_cond : le_cond;
    assign ind_sum = core.data_pointer + {8'h00, core.acc};

    // ------------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------------
    // mode caught once after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_mode_q <= 1'b0;
            mode_cap_q <= 1'b0;
        end else if (!mode_cap_q) begin
            src_mode_q <= src_mode;
            mode_cap_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Execution sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= S_IDLE;
            kind_q     <= xfer_pkg::K_NONE;
            base_q     <= '0;
            rel_q      <= 8'h00;
            zf_q       <= 1'b0;
            cf_q       <= 1'b0;
            acc_q      <= 8'h00;
            dp_q       <= 16'h0000;
            bitv_q     <= 1'b0;
            cnt_q      <= 3'h0;
            bit_rd_q   <= 1'b0;
            bit_addr_q <= 8'h00;
            done_q     <= 1'b0;
            done_hit_q <= 1'b0;
            taken_q    <= 1'b0;
            next_pc_q  <= '0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                S_IDLE: if (take) begin
                    kind_q  <= dec_kind;
                    base_q  <= base;
                    rel_q   <= dec_rel;
                    zf_q    <= core.zero_flag;
                    cf_q    <= core.carry_flag;
                    acc_q   <= core.acc;
                    dp_q    <= core.data_pointer;
                    state_q <= S_WAIT;
                    taken_q <= 1'b0;
                    next_pc_q <= base;
                    cnt_q <= st_count(dec_kind, src_mode_q, 1'b0);
                    unique case (dec_kind)
                        xfer_pkg::K_GT, xfer_pkg::K_LE: begin
                            taken_q <= jcond;
                            cnt_q <= st_count(dec_kind, src_mode_q, jcond);
                            if (jcond) begin
                                next_pc_q <= rel_add(base, dec_rel);
                            end
                        end
                        xfer_pkg::K_IND: begin
                            // low sixteen bits replaced by the sum
                            taken_q   <= 1'b1;
                            next_pc_q <= {req_pc[PC_W-1:16], ind_sum};
                        end
                        xfer_pkg::K_BCLR: begin
                            // read strobe only, no write path
                            bit_rd_q   <= 1'b1;
                            bit_addr_q <= dec_bit;
                            state_q    <= S_BIT;
                        end
                        xfer_pkg::K_NONE: next_pc_q <= req_pc;
                        default: next_pc_q <= req_pc;
                    endcase
                end
                S_BIT: begin
                    // displacement added when bit is zero
                    bit_rd_q <= 1'b0;
                    bitv_q   <= bit_value;
                    taken_q  <= !bit_value;
                    cnt_q <= st_count(kind_q, src_mode_q, !bit_value) - 3'h1;
                    if (!bit_value) begin
                        next_pc_q <= rel_add(base_q, rel_q);
                    end
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    // result released after its state count
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        done_q     <= 1'b1;
                        done_hit_q <= kind_q != xfer_pkg::K_NONE;
                        state_q    <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ready_q <= 1'b0;
        end else begin
            req_ready_q <= en_q && mode_cap_q &&
                           ((state_q == S_IDLE && !take) ||
                            (state_q == S_WAIT && cnt_q == 3'h1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 16'h0000;
        end else if (done_q && done_hit_q) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------------
    xfer_pkg::status_t status;

    always_comb begin
        status          = '0;
        status.kind     = kind_q;
        status.taken    = taken_q;
        status.busy     = state_q != S_IDLE;
        status.src_mode = src_mode_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= 1'b0;
            if (psel && penable && !pready_q) begin
                prdata_q <= 32'h0000_0000;
                unique case (paddr)
                    xfer_pkg::REG_CTRL:    prdata_q <= {31'h0, en_q};
                    xfer_pkg::REG_STATUS:  prdata_q <= status;
                    xfer_pkg::REG_NEXT_PC: prdata_q <= 32'(next_pc_q);
                    xfer_pkg::REG_COUNT:   prdata_q <= {16'h0, count_q};
                    default:               pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= xfer_pkg::CTRL_EN_RST;
        end else if (psel && penable && pready_q && pwrite &&
                     paddr == xfer_pkg::REG_CTRL) begin
            en_q <= pwdata[xfer_pkg::CTRL_EN_BIT];
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign req_ready  = req_ready_q;
    assign bit_rd     = bit_rd_q;
    assign bit_addr   = bit_addr_q;
    assign done       = done_q;
    assign done_hit   = done_hit_q;
    assign done_taken = taken_q;
    assign next_pc    = next_pc_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_gt_target: assert property (
        done_q && kind_q == xfer_pkg::K_GT |-> next_pc_q ==
        ((!zf_q && !cf_q) ? rel_add(base_q, rel_q) : base_q))
        else $error("greater jump target wrong");
    chk_le_target: assert property (
        done_q && kind_q == xfer_pkg::K_LE |-> next_pc_q ==
        ((zf_q || cf_q) ? rel_add(base_q, rel_q) : base_q))
        else $error("less-or-equal jump target wrong");
    chk_prefix_need: assert property (
        take && !src_mode_q && req_instr.b0 != xfer_pkg::ESC_PREFIX |=>
        kind_q != xfer_pkg::K_GT && kind_q != xfer_pkg::K_LE)
        else $error("conditional jump decoded without prefix");
    chk_ind_sum: assert property (
        done_q && kind_q == xfer_pkg::K_IND |->
        next_pc_q[15:0] == dp_q + {8'h00, acc_q})
        else $error("indirect jump sum wrong");
    chk_operand_hold: assert property (
        state_q != S_IDLE |=> $stable(acc_q) && $stable(dp_q))
        else $error("operands changed during execution");
    chk_ind_states: assert property (
        take && dec_kind == xfer_pkg::K_IND |=> !done_q[*5] ##1 done_q)
        else $error("indirect jump not five states");
    chk_bclr_target: assert property (
        done_q && kind_q == xfer_pkg::K_BCLR |-> next_pc_q ==
        (!bitv_q ? rel_add(base_q, rel_q) : base_q))
        else $error("bit-clear jump target wrong");
    chk_bit_read: assert property (
        bit_rd_q |-> state_q == S_BIT ##1 !bit_rd_q)
        else $error("bit access not a single read");
    chk_mode_fixed: assert property (
        mode_cap_q |=> $stable(src_mode_q) && mode_cap_q)
        else $error("mode changed after capture");

endmodule : branch_jump_execute

// ===== verification/test_branch_jump_execute.sv
`timescale 1ns/1ps
`define CHECK_EQ(what, exp, got) \
    begin checked++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    fail_count++; end end
module test_branch_jump_execute;
    // ------------------------------------------------------------------
    // Stimulus signals
    // ------------------------------------------------------------------
    logic                  pclk      = 1'b0;
    logic                  presetn   = 1'b0;
    logic [7:0]            paddr     = 8'h00;
    logic                  psel      = 1'b0;
    logic                  penable   = 1'b0;
    logic                  pwrite    = 1'b0;
    logic [31:0]           pwdata    = 32'h0;
    logic                  src_mode  = 1'b0;
    logic                  req_valid = 1'b0;
    logic [23:0]           req_pc    = 24'h0;
    xfer_pkg::instr_t      req_instr = '0;
    xfer_pkg::core_state_t core      = '0;
    logic                  bit_level = 1'b0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  req_ready;
    logic                  bit_rd;
    logic [7:0]            bit_addr;
    logic                  done;
    logic                  done_hit;
    logic                  done_taken;
    logic [23:0]           next_pc;
    logic [7:0]            seen_addr = 8'h00;
    logic [31:0]           rd;
    logic                  err;
    int                    fail_count = 0;
    int                    checked    = 0;
    wire logic             bit_value  = bit_rd ? bit_level : ~bit_level;

    always #50 pclk = ~pclk;

    always @(posedge pclk) begin
        if (bit_rd) begin
            seen_addr <= bit_addr;
        end
    end

    branch_jump_execute #(.PC_W(24)) branch_jump_execute_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_mode(src_mode), .req_valid(req_valid), .req_ready(req_ready),
        .req_pc(req_pc), .req_instr(req_instr), .core(core),
        .bit_rd(bit_rd), .bit_addr(bit_addr), .bit_value(bit_value),
        .done(done), .done_hit(done_hit), .done_taken(done_taken),
        .next_pc(next_pc)
    );

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic do_reset(input logic mode);
        @(posedge pclk);
        presetn  <= 1'b0;
        src_mode <= mode;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [23:0] tgt(input logic [23:0] pc,
                                        input logic [2:0] len,
                                        input logic [7:0] rel);
        tgt = pc + {21'h0, len} + {{16{rel[7]}}, rel};
    endfunction : tgt

    // Offers one instruction and checks result, timing and target.
    task automatic exec(input logic [31:0] ins, input logic [23:0] pc,
                        input logic [1:0] zc, input logic bv,
                        input logic [23:0] exp_pc, input logic hit,
                        input logic tk, input logic [2:0] states);
        int n;
        n = 0;
        @(posedge pclk);
        req_instr <= ins;
        req_pc    <= pc;
        core      <= {zc, 8'hff, 16'hff80};
        bit_level <= bv;
        req_valid <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (req_ready !== 1'b1 && n < 99);
        req_valid <= 1'b0;
        n = 0;
        @(negedge pclk);
        while (done !== 1'b1 && n < 20) begin
            @(negedge pclk);
            n++;
        end
        `CHECK_EQ("states", {5'h0, states}, n[7:0])
        `CHECK_EQ("next_pc", exp_pc, next_pc)
        `CHECK_EQ("done_hit", hit, done_hit)
        `CHECK_EQ("done_taken", tk, done_taken)
    endtask : exec

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset(1'b0);
        apb(1'b0, xfer_pkg::REG_CTRL, 32'h0);
        `CHECK_EQ("ctrl", 32'h1, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHECK_EQ("unmapped", 33'h100000000, {err, rd})
        apb(1'b1, xfer_pkg::REG_CTRL, 32'h0);
        repeat (4) @(negedge pclk);
        `CHECK_EQ("ready_off", 1'b0, req_ready)
        apb(1'b1, xfer_pkg::REG_CTRL, 32'h1);
        exec({16'hf0, xfer_pkg::OP_GT, xfer_pkg::ESC_PREFIX}, 24'h1000,
             2'b00, 0, 24'h0ff3, 1, 1, xfer_pkg::ST_COND_BIN_T);
        exec({16'hf0, xfer_pkg::OP_GT, xfer_pkg::ESC_PREFIX}, 24'h1000,
             2'b10, 0, 24'h1003, 1, 0, xfer_pkg::ST_COND_BIN_NT);
        exec({16'hf0, xfer_pkg::OP_GT, xfer_pkg::ESC_PREFIX}, 24'h1000,
             2'b01, 0, 24'h1003, 1, 0, xfer_pkg::ST_COND_BIN_NT);
        exec({16'h20, xfer_pkg::OP_LE, xfer_pkg::ESC_PREFIX}, 24'h1000,
             2'b01, 0, tgt(24'h1000, 3'h3, 8'h20), 1, 1,
             xfer_pkg::ST_COND_BIN_T);
        exec({16'h20, xfer_pkg::OP_LE, xfer_pkg::ESC_PREFIX}, 24'h1000,
             2'b10, 0, 24'h1023, 1, 1, xfer_pkg::ST_COND_BIN_T);
        exec({16'h20, xfer_pkg::OP_LE, xfer_pkg::ESC_PREFIX}, 24'h1000,
             2'b00, 0, 24'h1003, 1, 0, xfer_pkg::ST_COND_BIN_NT);
        exec({24'h10, xfer_pkg::OP_GT}, 24'h1000,
             2'b00, 0, 24'h1000, 0, 0, xfer_pkg::ST_NONE);
        exec({24'h0, xfer_pkg::OP_IND}, 24'h123456,
             2'b00, 0, 24'h12007f, 1, 1, xfer_pkg::ST_IND);
        exec({16'h7f2b, xfer_pkg::OP_BCLR}, 24'h2000,
             2'b00, 0, tgt(24'h2000, 3'h3, 8'h7f), 1, 1,
             xfer_pkg::ST_BCLR_T);
        `CHECK_EQ("bit_addr", 8'h2b, seen_addr)
        exec({16'h802b, xfer_pkg::OP_BCLR}, 24'h2000,
             2'b00, 1, 24'h2003, 1, 0, xfer_pkg::ST_BCLR_NT);
        apb(1'b0, xfer_pkg::REG_COUNT, 32'h0);
        `CHECK_EQ("count", 16'h9, rd[15:0])
        do_reset(1'b1);
        apb(1'b0, xfer_pkg::REG_STATUS, 32'h0);
        `CHECK_EQ("status_mode", 1'b1, rd[0])
        // The strap moves after capture; source decoding must stay.
        src_mode <= 1'b0;
        exec({24'h05, xfer_pkg::OP_GT}, 24'h3000,
             2'b00, 0, 24'h3007, 1, 1, xfer_pkg::ST_COND_SRC_T);
        exec({24'h05, xfer_pkg::OP_LE}, 24'h3000,
             2'b00, 0, 24'h3002, 1, 0, xfer_pkg::ST_COND_SRC_NT);
        exec({16'h05, xfer_pkg::OP_GT, xfer_pkg::ESC_PREFIX}, 24'h3000,
             2'b00, 0, 24'h3000, 0, 0, xfer_pkg::ST_NONE);
        exec({24'h0, xfer_pkg::OP_IND}, 24'hab0000,
             2'b11, 0, 24'hab007f, 1, 1, xfer_pkg::ST_IND);
        apb(1'b0, xfer_pkg::REG_NEXT_PC, 32'h0);
        `CHECK_EQ("next_pc_reg", 32'h00ab007f, rd)
        test_done();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        test_done();
    end
endmodule : test_branch_jump_execute
